// File: design/strap_budget_pkg.sv
// constants and carrier types for the strap status and budget data bank
// assumes a 12-bit APB byte address and 32-bit data words
package strap_budget_pkg;

    // bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // register byte addresses
    localparam logic [11:0] BUDGET_SEL_OFF = 12'h284;
    localparam logic [11:0] BUDGET_READ_OFF = 12'h288;
    localparam logic [11:0] BUDGET_BASE_OFF = 12'h300;
    localparam logic [11:0] STATUS_OFF = 12'h400;
    localparam logic [11:0] SYS_CTRL_OFF = 12'h500;
    localparam logic [11:0] WORD_BYTES = 12'h004;

    // budget bank shape
    localparam int BUDGET_WORDS = 8;
    localparam int BUDGET_IDX_W = 3;
    localparam logic [7:0] SEL_MAX = 8'h07;
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // control register field
    localparam int UNLOCK_BIT = 0;

    // operating mode codes
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_NORMAL_EE = 4'h1;
    localparam logic [3:0] MODE_FO_P0 = 4'h8;
    localparam logic [3:0] MODE_FO_P2 = 4'h9;
    localparam logic [3:0] MODE_FO_EE_P0 = 4'hA;
    localparam logic [3:0] MODE_FO_EE_P2 = 4'hB;

    // edges after fundamental reset release before straps are taken
    localparam logic [1:0] CAP_SETTLE = 2'h2;

    // strap pins as sampled at the board
    typedef struct packed {
        logic halt_after_reset;
        logic reference_clock_mode;
        logic master_smbus_slow;
        logic common_clock_upstream;
        logic common_clock_downstream;
        logic [3:0] operating_mode_straps;
    } strap_pins_t;

    localparam int STRAP_W = 9;

    // status word layout, bit 31 down to bit 0
    typedef struct packed {
        logic [21:0] rsvd_hi;
        logic halt_after_reset;
        logic reference_clock_mode;
        logic master_smbus_slow;
        logic common_clock_upstream;
        logic common_clock_downstream;
        logic rsvd4;
        logic [3:0] operating_mode_straps;
    } status_word_t;

    // one APB request as seen in the access phase
    typedef struct packed {
        logic [11:0] paddr;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage

// File: design/strap_capture.sv
// strap and hot reset synchroniser with a one-time strap capture
// assumes pins are asynchronous to CLK and straps are static after release
`timescale 1ns/1ps
module strap_capture import strap_budget_pkg::*; (
    // clock and fundamental reset
    input wire logic clk,
    input wire logic rst_b,
    // raw pins
    input wire logic hot_pin_b,
    input wire strap_pins_t strap_pins,
    // synchronised hot reset, low while asserted
    output logic hot_rst_b_sync,
    // captured straps and their valid flag
    output strap_pins_t straps_q,
    output logic valid_q
);

    // capture sequencer states
    typedef enum logic [0:0] {
        CAP_WAIT = 1'b0,
        CAP_HELD = 1'b1
    } cap_state_t;

    logic [STRAP_W:0] raw; // hot reset on top, straps below
    logic [STRAP_W:0] meta_q; // first stage, read only by second
    logic [STRAP_W:0] sync_q; // second stage
    cap_state_t state_q;
    logic [1:0] cnt_q; // edges since release

    assign raw = {hot_pin_b, strap_pins};
    assign hot_rst_b_sync = sync_q[STRAP_W];

    // two flip-flops per pin bit
    genvar g;
    generate
        for (g = 0; g <= STRAP_W; g++) begin : g_sync
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                end else begin
                    meta_q[g] <= raw[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    // capture once, after the synchronisers have filled
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= CAP_WAIT;
            cnt_q <= 2'h0;
            straps_q <= '0;
            valid_q <= 1'b0;
        end else begin
            unique case (state_q)
                CAP_WAIT: begin
                    if (cnt_q == CAP_SETTLE) begin
                        straps_q <= sync_q[STRAP_W-1:0];
                        valid_q <= 1'b1;
                        state_q <= CAP_HELD;
                    end else begin
                        cnt_q <= cnt_q + 2'h1;
                    end
                end
                CAP_HELD: begin
                    // held until the next fundamental reset
                    state_q <= CAP_HELD;
                end
            endcase
        end
    end

endmodule

// File: design/switch_strap_status_and_budget_data.sv
// APB register bank: power budget data words and strap-based switch status
// assumes an APB master on CLK, RST_B as fundamental reset, HOT_RST_B
// and strap pins arriving asynchronously from the board
// budget words ride through hot reset; straps are taken once per fundamental reset
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps

// Operation
// - budget words writable only while unlocked
// - locked budget writes are dropped silently
// - mode field bits 3:0, codes 0,1
// - codes 8 to B select failover variants
// - bit 5 downstream common clock strap
// - bit 6 upstream common clock strap
// - bit 7 master SMBus slow strap
// - bit 8 reference clock mode strap
// - bit 9 halt after reset strap
// - select above 7 reads zero readout
// - budget words survive hot reset
module switch_strap_status_and_budget_data import strap_budget_pkg::*; (
    // clock and resets
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic HOT_RST_B,
    // board strap pins
    input wire strap_pins_t STRAPS,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // decoded operating mode
    output logic MODE_EEPROM_INIT,
    output logic MODE_FAILOVER,
    output logic UPSTREAM_PORT2,
    output logic MODE_RESERVED,
    output logic STRAPS_VALID
);

    // synchronised hot reset, low while asserted
    logic hot_b;
    // straps as captured after fundamental reset
    strap_pins_t straps;
    // capture done flag
    logic straps_ok;

    // request bundle for the access phase
    apb_req_t req;

    // answer registers
    // prdata holds between transfers; only the first access cycle reloads it
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pslverr_q;
    logic pslverr_d;

    // decoded mode registers
    logic ee_q;
    logic ee_d;
    logic fo_q;
    logic fo_d;
    logic up2_q;
    logic up2_d;
    logic rsvd_q;
    logic rsvd_d;
    logic valid_q;

    // budget bank, select and unlock
    logic [31:0] budget_q [BUDGET_WORDS];
    logic [7:0] sel_q;
    logic unlock_q;

    // address decode
    logic [BUDGET_WORDS-1:0] word_hit;
    logic [BUDGET_WORDS-1:0] word_we; // hit, committed and unlocked
    logic budget_hit;
    logic sel_hit;
    logic read_hit;
    logic status_hit;
    logic ctrl_hit;
    logic mapped;

    // phase strobes
    logic access;
    logic commit;
    logic wr_commit;

    // readout and status views
    logic [31:0] readout;
    status_word_t status;

    // strap synchroniser and one-shot capture
    // the hot reset pin rides through the same two-flop chain there
    strap_capture u_capture (
        .clk(CLK),
        .rst_b(RST_B),
        .hot_pin_b(HOT_RST_B),
        .strap_pins(STRAPS),
        .hot_rst_b_sync(hot_b),
        .straps_q(straps),
        .valid_q(straps_ok)
    );

    // group the APB request so decode reads one bundle
    assign req = '{paddr: PADDR, pwrite: PWRITE, pwdata: PWDATA};

    // both strobes decode the same signals and differ only in ready,
    // so access and commit can never be high together
    // first access cycle computes the answer, the second one completes
    assign access = PSEL & PENABLE & ~pready_q;
    // the edge where pready is sampled high is the only commit edge
    assign commit = PSEL & PENABLE & pready_q;
    // a locked budget write still completes, with no error flag
    // writes to unmapped space never land anywhere
    assign wr_commit = commit & req.pwrite & mapped;

    // one address comparator per budget word
    // each address is constant per word, so it folds to a plain equality test
    genvar w;
    generate
        for (w = 0; w < BUDGET_WORDS; w++) begin : g_word
            // word w sits one aligned word above word w-1
            assign word_hit[w] =
                (req.paddr == BUDGET_BASE_OFF + 12'(w) * WORD_BYTES);

            // lock folded into the strobe so the register stays plain
            assign word_we[w] = wr_commit & word_hit[w] & unlock_q;

            // sticky word: only fundamental reset clears it
            // reset contents are meaningless, software loads them
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    budget_q[w] <= WORD_RESET;
                end else if (word_we[w]) begin
                    // writable only while unlocked
                    budget_q[w] <= req.pwdata;
                end
                // locked writes fall through and change nothing
            end
        end
    endgenerate

    // remaining decode terms
    // anything outside these five terms answers with an error
    assign budget_hit = |word_hit;
    assign sel_hit = (req.paddr == BUDGET_SEL_OFF);
    assign read_hit = (req.paddr == BUDGET_READ_OFF);
    assign status_hit = (req.paddr == STATUS_OFF);
    assign ctrl_hit = (req.paddr == SYS_CTRL_OFF);
    assign mapped = budget_hit | sel_hit | read_hit | status_hit | ctrl_hit;

    // readout: out-of-range select gives zero, not an alias
    // the index is cut to three bits only behind the range test, so a
    // select of 8 or more can never fold onto a low word
    assign readout = (sel_q > SEL_MAX) ? READ_ZERO
        : budget_q[sel_q[BUDGET_IDX_W-1:0]];

    // status word built from the captured straps only
    always_comb begin
        // the blank default keeps bit 4 and bits 31:10 at zero
        status = '0;
        status.operating_mode_straps = straps.operating_mode_straps;
        status.common_clock_downstream = straps.common_clock_downstream;
        status.common_clock_upstream = straps.common_clock_upstream;
        status.master_smbus_slow = straps.master_smbus_slow;
        status.reference_clock_mode = straps.reference_clock_mode;
        status.halt_after_reset = straps.halt_after_reset;
    end

    // read mux and error answer for the addressed register
    // decode terms are one-hot, so the order of the chain is free
    always_comb begin
        prdata_d = READ_ZERO;
        pslverr_d = 1'b0;
        if (budget_hit) begin
            // budget words read back whether locked or not
            // word_hit is one-hot, so one pass of the loop at most assigns
            for (int i = 0; i < BUDGET_WORDS; i++) begin
                if (word_hit[i]) begin
                    prdata_d = budget_q[i];
                end
            end
        end else if (sel_hit) begin
            // select field in the low byte, the rest reads zero
            prdata_d = 32'(sel_q);
        end else if (read_hit) begin
            // selected budget word or zero
            prdata_d = readout;
        end else if (status_hit) begin
            // read-only view of the straps
            prdata_d = status;
        end else if (ctrl_hit) begin
            // stands in for the system control word of the full switch
            // unlock bit alone, upper bits read zero
            prdata_d = READ_ZERO;
            prdata_d[UNLOCK_BIT] = unlock_q;
        end else begin
            // unmapped: zero data and an error flag
            pslverr_d = 1'b1;
        end
    end

    // one wait state: ready rises one cycle into the access phase
    // trading a cycle of latency for a registered read path
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pready_q <= 1'b0;
        end else if (commit) begin
            // drop ready as the transfer completes
            pready_q <= 1'b0;
        end else if (!PSEL) begin
            // a transfer abandoned by the master leaves no stale ready behind
            pready_q <= 1'b0;
        end else if (access) begin
            // answer is ready on the next edge
            pready_q <= 1'b1;
        end
    end

    // read data and error are caught with the ready rise
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            prdata_q <= READ_ZERO;
            pslverr_q <= 1'b0;
        end else if (access) begin
            // writes see zero data, which the master ignores
            prdata_q <= req.pwrite ? READ_ZERO : prdata_d;
            pslverr_q <= pslverr_d;
        end else if (commit) begin
            // error lasts only for the completing cycle
            pslverr_q <= 1'b0;
        end
    end

    // hot reset reaches only the plain fields below; the sticky words and
    // the captured straps never see it
    // budget select: ordinary field, hot reset clears it
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            sel_q <= SEL_RESET;
        end else if (!hot_b) begin
            // not sticky, so a hot reset restores the default
            sel_q <= SEL_RESET;
        end else if (wr_commit && sel_hit) begin
            // full byte stored; range checked on readout
            sel_q <= req.pwdata[$bits(sel_q)-1:0];
        end
    end

    // unlock bit gating the budget bank, cleared by any reset
    // so a reset never leaves the sticky words exposed
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            unlock_q <= 1'b0;
        end else if (!hot_b) begin
            unlock_q <= 1'b0;
        end else if (wr_commit && ctrl_hit) begin
            // the gate that steers budget writes
            // the other bits of the control word are dropped
            unlock_q <= req.pwdata[UNLOCK_BIT];
        end
    end

    // status writes: no branch stores them, so they are ignored

    // mode decode from the captured straps
    // reserved codes are decoded too, so a badly strapped board shows up
    always_comb begin
        ee_d = 1'b0;
        fo_d = 1'b0;
        up2_d = 1'b0;
        rsvd_d = 1'b0;
        unique case (straps.operating_mode_straps)
            MODE_NORMAL: begin
                // plain switching
                ee_d = 1'b0;
            end
            MODE_NORMAL_EE: begin
                // switching with EEPROM load
                ee_d = 1'b1;
            end
            MODE_FO_P0: begin
                // failover, port 0 upstream
                fo_d = 1'b1;
            end
            MODE_FO_P2: begin
                // failover, port 2 upstream
                fo_d = 1'b1;
                up2_d = 1'b1;
            end
            MODE_FO_EE_P0: begin
                // failover with EEPROM, port 0
                ee_d = 1'b1;
                fo_d = 1'b1;
            end
            MODE_FO_EE_P2: begin
                // failover with EEPROM, port 2
                ee_d = 1'b1;
                fo_d = 1'b1;
                up2_d = 1'b1;
            end
            default: begin
                // board should never strap these codes
                rsvd_d = 1'b1;
            end
        endcase
    end

    // decoded mode outputs, held at zero until capture is done
    // the gate keeps the decode quiet while the synchronisers still hold zeros
    // straps are assumed static after release, so no re-sampling
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ee_q <= 1'b0;
            fo_q <= 1'b0;
            up2_q <= 1'b0;
            rsvd_q <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            ee_q <= ee_d & straps_ok;
            fo_q <= fo_d & straps_ok;
            up2_q <= up2_d & straps_ok;
            rsvd_q <= rsvd_d & straps_ok;
            valid_q <= straps_ok;
        end
    end

    // every output comes straight from a flip-flop
    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign MODE_EEPROM_INIT = ee_q;
    assign MODE_FAILOVER = fo_q;
    assign UPSTREAM_PORT2 = up2_q;
    assign MODE_RESERVED = rsvd_q;
    assign STRAPS_VALID = valid_q;

endmodule

// File: dv/switch_strap_status_and_budget_data_properties.sv
// checker for the strap status and budget data bank, bound to its top ports
// assumes the board keeps the mode straps static while the design runs
`timescale 1ns/1ps
module strap_budget_properties import strap_budget_pkg::*; (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // straps and bus
    input wire strap_pins_t STRAPS,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    // decoded mode outputs
    input wire logic MODE_EEPROM_INIT,
    input wire logic MODE_FAILOVER,
    input wire logic UPSTREAM_PORT2,
    input wire logic MODE_RESERVED,
    input wire logic STRAPS_VALID
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // live mode pins, valid to compare because they never move after release
    wire logic [3:0] md = STRAPS.operating_mode_straps;
    // completing status read
    wire logic rd_sts = PSEL && PENABLE && PREADY && !PWRITE && PADDR == STATUS_OFF;

    property p_ee;
        STRAPS_VALID |-> MODE_EEPROM_INIT == (md == 4'h1 || md[3:1] == 3'b101);
    endproperty
    a_ee: assert property (p_ee)
        else $error("eeprom init flag wrong");
    property p_fo;
        STRAPS_VALID |-> MODE_FAILOVER == (md[3:2] == 2'b10);
    endproperty
    a_fo: assert property (p_fo)
        else $error("failover flag wrong");
    property p_up2;
        STRAPS_VALID |-> UPSTREAM_PORT2 == (md == 4'h9 || md == 4'hB);
    endproperty
    a_up2: assert property (p_up2)
        else $error("upstream port flag wrong");
    property p_rsvd;
        STRAPS_VALID |-> MODE_RESERVED == !(md[3:1] == 3'b000 || md[3:2] == 2'b10);
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved mode flag wrong");
    property p_smode;
        rd_sts && STRAPS_VALID |-> PRDATA[3:0] == md;
    endproperty
    a_smode: assert property (p_smode)
        else $error("status mode field wrong");
    property p_szero;
        rd_sts |-> PRDATA[31:10] == 22'h0 && !PRDATA[4];
    endproperty
    a_szero: assert property (p_szero)
        else $error("status spare bits not zero");
    property p_vhold;
        STRAPS_VALID |=> STRAPS_VALID;
    endproperty
    a_vhold: assert property (p_vhold)
        else $error("strap capture lost");
    property p_vrise;
        $rose(STRAPS_VALID) |-> $past(RST_B, 3);
    endproperty
    a_vrise: assert property (p_vrise)
        else $error("strap capture too early");
    property p_wait;
        PSEL && PENABLE && !PREADY |=> PREADY;
    endproperty
    a_wait: assert property (p_wait)
        else $error("ready late");
    property p_rdy;
        PREADY |-> PSEL && PENABLE && $past(PSEL);
    endproperty
    a_rdy: assert property (p_rdy)
        else $error("ready outside access");
endmodule

bind switch_strap_status_and_budget_data strap_budget_properties strap_budget_properties_i (
    .CLK(CLK), .RST_B(RST_B), .STRAPS(STRAPS), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .MODE_EEPROM_INIT(MODE_EEPROM_INIT), .MODE_FAILOVER(MODE_FAILOVER),
    .UPSTREAM_PORT2(UPSTREAM_PORT2), .MODE_RESERVED(MODE_RESERVED),
    .STRAPS_VALID(STRAPS_VALID));

// File: dv/testbench.sv
// self-checking bench for the strap status and budget data bank
// assumes one wait state per transfer; the bench drives all ports itself
`timescale 1ns/1ps
module testbench import strap_budget_pkg::*;;
    logic clk, rst_b, hot_rst_b, psel, penable, pwrite, pready, pslverr, sv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, lf, r;
    strap_pins_t straps, sp;
    logic [3:0] mc; // mode code drawn for each fundamental reset
    logic [31:0] bw [8]; // model of the budget words
    logic e;
    int bad_count, n_checks;

    switch_strap_status_and_budget_data switch_strap_status_and_budget_data_i (
        .CLK(clk), .RST_B(rst_b), .HOT_RST_B(hot_rst_b), .STRAPS(straps),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .MODE_EEPROM_INIT(), .MODE_FAILOVER(), .UPSTREAM_PORT2(),
        .MODE_RESERVED(), .STRAPS_VALID(sv));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // next value of the stimulus shift register
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // byte address of budget word i
    function automatic logic [11:0] wa(input int i);
        return BUDGET_BASE_OFF + WORD_BYTES * 12'(i);
    endfunction
    // status word expected from captured straps
    function automatic logic [31:0] xs(input strap_pins_t s);
        return {22'h0, s.halt_after_reset, s.reference_clock_mode, s.master_smbus_slow,
            s.common_clock_upstream, s.common_clock_downstream, 1'b0, s.operating_mode_straps};
    endfunction

    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            bad_count++;
            $display("ERROR %0t seen %h want %h", $time, s, x);
        end
    endtask

    // one transfer; entered just after a rising edge, idles one cycle after
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        if (n >= 20) begin
            chk(32'h0, 32'h1);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r, x);
    endtask

    // fundamental reset with given straps, then wait for capture
    task automatic do_reset(input strap_pins_t s);
        int n;
        n = 0;
        rst_b <= 1'b0;
        straps <= s;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        while (sv !== 1'b1 && n < 10) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, sv}, 32'h1);
    endtask

    task automatic summarize();
        if (bad_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog: far beyond the under a thousand cycles the tests need
    initial begin
        #200000;
        bad_count++;
        summarize();
    end

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        hot_rst_b = 1'b1;
        straps = '0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        lf = 32'h1A76;
        @(posedge clk);
        // legal mode codes only, random other straps; writes to status are dropped
        for (int m = 0; m < 16; m++) begin
            lf = nxt(lf);
            mc = 4'(m % 6);
            if (mc > MODE_NORMAL_EE) begin
                mc = mc + 4'h6; // 2 to 5 become the failover codes 8 to B
            end
            sp = strap_pins_t'({lf[8:4], mc}); // reserved codes never strapped
            do_reset(sp);
            rdc(STATUS_OFF, xs(sp));
            wr(STATUS_OFF, ~xs(sp));
            rdc(STATUS_OFF, xs(sp));
        end
        // unlocked: all ones and random words
        wr(SYS_CTRL_OFF, 32'h1);
        for (int i = 0; i < 8; i++) begin
            lf = nxt(lf);
            bw[i] = (i == 0) ? 32'hFFFF_FFFF : lf;
            wr(wa(i), bw[i]);
        end
        // readout by select, including selects beyond the bank
        for (int i = 0; i < 10; i++) begin
            wr(BUDGET_SEL_OFF, (i == 9) ? 32'hFF : 32'(i));
            rdc(BUDGET_READ_OFF, (i < 8) ? bw[i] : 32'h0);
            if (i < 8) begin
                rdc(wa(i), bw[i]);
            end
        end
        // locked: writes ignored
        wr(SYS_CTRL_OFF, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wr(wa(i), ~bw[i]);
            rdc(wa(i), bw[i]);
        end
        // hot reset with straps moving: words and captured straps kept
        wr(SYS_CTRL_OFF, 32'h1);
        hot_rst_b <= 1'b0;
        straps <= strap_pins_t'(sp ^ 9'h1F0); // mode bits stay put
        repeat (4) @(posedge clk);
        hot_rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rdc(wa(i), bw[i]);
        end
        rdc(STATUS_OFF, xs(sp));
        // unlock cleared by the hot reset, so this write is dropped
        wr(wa(5), 32'h0);
        rdc(wa(5), bw[5]);
        // unmapped address
        apb(1'b0, 12'h104, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        summarize();
    end
endmodule
